// >>> exi_defines.svh
// Register map, field positions, reset values and pin codes of the external interrupt block
`ifndef EXI_DEFINES_SVH
`define EXI_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EXI_ADDR_PRIO2 8'hF7
`define EXI_ADDR_CFG 8'hE4
`define EXI_ADDR_TCTL 8'h88
`define EXI_ADDR_SKIP 8'hD4
`define EXI_ADDR_IST 8'hC0
`define EXI_ADDR_ICLR 8'hC1
`define EXI_ADDR_IEN 8'hC2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EXI_TCTL_EDGE0 0
`define EXI_TCTL_PEND0 1
`define EXI_TCTL_EDGE1 2
`define EXI_TCTL_PEND1 3
`define EXI_CFG_POL0 3
`define EXI_CFG_POL1 7
`define EXI_CFG_SEL0_LO 0
`define EXI_CFG_SEL1_LO 4

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define EXI_PRIO2_RST 8'h00
`define EXI_PRIO2_WMASK 8'h0F
`define EXI_SEL0_RST 3'h1
`define EXI_SEL1_RST 3'h0
`define EXI_POL_RST 2'h0
`define EXI_EDGE_RST 2'h0
`define EXI_SKIP_RST 8'h00
`define EXI_IEN_RST 2'h0
`define EXI_PEND_RST 2'h0
`define EXI_IST_RST 2'h0
`define EXI_SYNC_RST 8'hFF
`define EXI_ACT_PREV_RST 2'h3
`define EXI_OUT_RST 8'h00
`define EXI_IRQ_RST 1'h0

// ----------------------------------------------------------------
// Pin select codes
// ----------------------------------------------------------------
`define EXI_SEL_P1_6 3'h6
`define EXI_SEL_P1_7 3'h7

`endif

// >>> exi_pkg.sv
// Types of the external interrupt and priority block
package exi_pkg;

  // ----------------------------------------------------------------
  // Whole state of the block, registered as one word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prio;
    logic [1:0] edge_mode;
    logic [1:0] pend;
    logic [1:0] pol;
    logic [1:0][2:0] sel;
    logic [7:0] skip;
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [1:0] act_prev;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] req_hi;
    logic [7:0] req_lo;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } exi_state_t;

endpackage : exi_pkg

// >>> exi_top.sv
// External interrupt inputs, pending flags and second priority register
`timescale 1ns/1ps
`include "exi_defines.svh"

module exi_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,

  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,

  // Port pins seen by the interrupt inputs
  input wire logic [7:0] port0_pin_i,
  input wire logic [7:0] port1_pin_i,

  // Crossbar peripheral drive toward the monitored pins
  input wire logic [7:0] periph_out_i,
  input wire logic [7:0] periph_oe_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] crossbar_skip_o,

  // Eight on-chip sources and their priority split
  input wire logic [7:0] src_irq_i,
  output logic [7:0] src_req_high_o,
  output logic [7:0] src_req_low_o,

  // CPU interrupt sequencer
  input wire logic [1:0] ext_irq_vector_i,
  output logic [1:0] ext_irq_pending_o,

  // Block interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------
  localparam exi_pkg::exi_state_t RESET_S = '{
    prio: `EXI_PRIO2_RST,
    edge_mode: `EXI_EDGE_RST,
    pend: `EXI_PEND_RST,
    pol: `EXI_POL_RST,
    sel: {`EXI_SEL1_RST, `EXI_SEL0_RST},
    skip: `EXI_SKIP_RST,
    // Idle image in the synchronisers so release makes no false edge
    sync_a: `EXI_SYNC_RST,
    sync_b: `EXI_SYNC_RST,
    act_prev: `EXI_ACT_PREV_RST,
    ist: `EXI_IST_RST,
    ien: `EXI_IEN_RST,
    rdata: `EXI_OUT_RST,
    irq: `EXI_IRQ_RST,
    req_hi: `EXI_OUT_RST,
    req_lo: `EXI_OUT_RST,
    pin_out: `EXI_OUT_RST,
    pin_oe: `EXI_OUT_RST
  };

  exi_pkg::exi_state_t state_q;
  exi_pkg::exi_state_t state_d;

  // ----------------------------------------------------------------
  // Per-input pin select and polarity
  // ----------------------------------------------------------------
  logic [7:0] cand_pin;
  logic [1:0] act;
  logic [1:0] act_edge;

  // Candidate pins in select-code order
  assign cand_pin = state_q.sync_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic sel_level;
      assign sel_level = cand_pin[state_q.sel[ch]];
      // Active when the pin matches the polarity
      assign act[ch] = state_q.pol[ch] ? sel_level : ~sel_level;
      assign act_edge[ch] = act[ch] & ~state_q.act_prev[ch];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decoded bus strobes
  // ----------------------------------------------------------------
  logic wr_prio;
  logic wr_cfg;
  logic wr_tctl;
  logic wr_skip;
  logic wr_iclr;
  logic wr_ien;

  assign wr_prio = reg_wr_i && (reg_addr_i == `EXI_ADDR_PRIO2);
  assign wr_cfg = reg_wr_i && (reg_addr_i == `EXI_ADDR_CFG);
  assign wr_tctl = reg_wr_i && (reg_addr_i == `EXI_ADDR_TCTL);
  assign wr_skip = reg_wr_i && (reg_addr_i == `EXI_ADDR_SKIP);
  assign wr_iclr = reg_wr_i && (reg_addr_i == `EXI_ADDR_ICLR);
  assign wr_ien = reg_wr_i && (reg_addr_i == `EXI_ADDR_IEN);

  // ----------------------------------------------------------------
  // Register images for reads
  // ----------------------------------------------------------------
  logic [7:0] tctl_img;
  logic [7:0] cfg_img;
  logic [1:0] tctl_pend_wr;

  always_comb begin
    tctl_img = 8'h00;
    tctl_img[`EXI_TCTL_EDGE0] = state_q.edge_mode[0];
    tctl_img[`EXI_TCTL_PEND0] = state_q.pend[0];
    tctl_img[`EXI_TCTL_EDGE1] = state_q.edge_mode[1];
    tctl_img[`EXI_TCTL_PEND1] = state_q.pend[1];
  end

  // ----------------------------------------------------------------
  // Configuration register image
  // ----------------------------------------------------------------
  always_comb begin
    cfg_img = 8'h00;
    cfg_img[`EXI_CFG_POL0] = state_q.pol[0];
    cfg_img[`EXI_CFG_POL1] = state_q.pol[1];
    cfg_img[`EXI_CFG_SEL0_LO +: 3] = state_q.sel[0];
    cfg_img[`EXI_CFG_SEL1_LO +: 3] = state_q.sel[1];
  end

  assign tctl_pend_wr = {reg_wdata_i[`EXI_TCTL_PEND1], reg_wdata_i[`EXI_TCTL_PEND0]};

  // ----------------------------------------------------------------
  // Candidate pin gather in select-code order
  // ----------------------------------------------------------------
  logic [7:0] pin_raw;

  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_gather
      if (gp == `EXI_SEL_P1_6 || gp == `EXI_SEL_P1_7) begin : g_port1
        assign pin_raw[gp] = port1_pin_i[gp];
      end else begin : g_port0
        assign pin_raw[gp] = port0_pin_i[gp];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Write data fields
  // ----------------------------------------------------------------
  logic [1:0] wr_pol;
  logic [1:0][2:0] wr_sel;
  logic [1:0] wr_edge;
  logic [7:0] prio_next;
  logic [7:0] skip_next;

  assign wr_pol = {reg_wdata_i[`EXI_CFG_POL1], reg_wdata_i[`EXI_CFG_POL0]};
  assign wr_sel = {reg_wdata_i[`EXI_CFG_SEL1_LO +: 3], reg_wdata_i[`EXI_CFG_SEL0_LO +: 3]};
  assign wr_edge = {reg_wdata_i[`EXI_TCTL_EDGE1], reg_wdata_i[`EXI_TCTL_EDGE0]};
  // Upper priority bits stay read-only zero
  assign prio_next = wr_prio ? ((state_q.prio & ~`EXI_PRIO2_WMASK) | (reg_wdata_i & `EXI_PRIO2_WMASK)) : state_q.prio;
  assign skip_next = wr_skip ? reg_wdata_i : state_q.skip;

  // ----------------------------------------------------------------
  // Pending flag per input
  // ----------------------------------------------------------------
  logic [1:0] pend_next;

  genvar pc;
  generate
    for (pc = 0; pc < 2; pc++) begin : g_pend
      logic pend_nx;
      always_comb begin
        pend_nx = state_q.pend[pc];
        if (state_q.edge_mode[pc]) begin
          // Software may set or clear the flag in edge mode only
          if (wr_tctl) begin
            pend_nx = tctl_pend_wr[pc];
          end
          if (ext_irq_vector_i[pc]) begin
            pend_nx = 1'b0;
          end
          // A new edge wins over any clear
          if (act_edge[pc]) begin
            pend_nx = 1'b1;
          end
        end else begin
          // Still active after the handler means a fresh request
          pend_nx = act[pc];
        end
      end
      assign pend_next[pc] = pend_nx;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sticky event status
  // ----------------------------------------------------------------
  logic [1:0] ist_clr;
  logic [1:0] ist_next;

  assign ist_clr = wr_iclr ? reg_wdata_i[1:0] : 2'h0;
  // Set wins over clear so no event is lost
  assign ist_next = (state_q.ist & ~ist_clr) | act_edge;

  // ----------------------------------------------------------------
  // Block interrupt
  // ----------------------------------------------------------------
  logic [1:0] ien_next;
  logic irq_next;

  assign ien_next = wr_ien ? reg_wdata_i[1:0] : state_q.ien;
  assign irq_next = |(ist_next & ien_next);

  // ----------------------------------------------------------------
  // Crossbar drive per monitored pin
  // ----------------------------------------------------------------
  logic [7:0] oe_next;

  genvar pn;
  generate
    for (pn = 0; pn < 8; pn++) begin : g_pin
      // A skipped pin is left to the interrupt input alone
      assign oe_next[pn] = periph_oe_i[pn] & ~state_q.skip[pn];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority split per on-chip source
  // ----------------------------------------------------------------
  logic [7:0] hi_next;
  logic [7:0] lo_next;

  genvar sr;
  generate
    for (sr = 0; sr < 8; sr++) begin : g_src
      assign hi_next[sr] = src_irq_i[sr] & state_q.prio[sr];
      assign lo_next[sr] = src_irq_i[sr] & ~state_q.prio[sr];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [7:0] rd_img;

  always_comb begin
    case (reg_addr_i)
      `EXI_ADDR_PRIO2: rd_img = state_q.prio;
      `EXI_ADDR_CFG: rd_img = cfg_img;
      `EXI_ADDR_TCTL: rd_img = tctl_img;
      `EXI_ADDR_SKIP: rd_img = state_q.skip;
      `EXI_ADDR_IST: rd_img = {6'h00, state_q.ist};
      `EXI_ADDR_IEN: rd_img = {6'h00, state_q.ien};
      default: rd_img = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // Two-flop pin synchronisers
    state_d.sync_a = pin_raw;
    state_d.sync_b = state_q.sync_a;
    state_d.act_prev = act;

    // Priority register, upper half read only
    state_d.prio = prio_next;

    // Polarity and pin select
    if (wr_cfg) begin
      state_d.pol = wr_pol;
      state_d.sel = wr_sel;
    end

    // Sensitivity bits
    if (wr_tctl) begin
      state_d.edge_mode = wr_edge;
    end

    // Crossbar skip bits
    state_d.skip = skip_next;

    // Pending flags, status and block interrupt
    state_d.pend = pend_next;
    state_d.ist = ist_next;
    state_d.ien = ien_next;
    state_d.irq = irq_next;

    // Priority split toward the CPU
    state_d.req_hi = hi_next;
    state_d.req_lo = lo_next;

    // Peripheral drive passes untouched unless the pin is skipped
    state_d.pin_out = periph_out_i;
    state_d.pin_oe = oe_next;

    // Read data stands one cycle after the strobe only
    state_d.rdata = reg_rd_i ? rd_img : 8'h00;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= RESET_S;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward software
  // ----------------------------------------------------------------
  assign reg_rdata_o = state_q.rdata;
  assign irq_o = state_q.irq;

  // ----------------------------------------------------------------
  // Outputs toward the crossbar
  // ----------------------------------------------------------------
  assign pin_out_o = state_q.pin_out;
  assign pin_oe_o = state_q.pin_oe;
  assign crossbar_skip_o = state_q.skip;

  // ----------------------------------------------------------------
  // Outputs toward the CPU
  // ----------------------------------------------------------------
  assign src_req_high_o = state_q.req_hi;
  assign src_req_low_o = state_q.req_lo;
  assign ext_irq_pending_o = state_q.pend;

endmodule : exi_top

// >>> exi_top_properties.sv
// Concurrent checks on the external interrupt block ports
`timescale 1ns/1ps
module exi_top_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Pins and crossbar
  input wire logic [7:0] port0_pin_i,
  input wire logic [7:0] port1_pin_i,
  input wire logic [7:0] periph_out_i,
  input wire logic [7:0] periph_oe_i,
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] crossbar_skip_o,
  // Sources and CPU side
  input wire logic [7:0] src_irq_i,
  input wire logic [7:0] src_req_high_o,
  input wire logic [7:0] src_req_low_o,
  input wire logic [1:0] ext_irq_vector_i,
  input wire logic [1:0] ext_irq_pending_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_split_union: assert property ($past(rst_n_i) |-> (src_req_high_o | src_req_low_o) == $past(src_irq_i))
    else $error("source request lost in priority split");
  a_split_excl: assert property (!(|(src_req_high_o & src_req_low_o)))
    else $error("source request on both priority levels");
  a_oe_skip: assert property ($past(rst_n_i) && $stable(crossbar_skip_o) |->
    pin_oe_o == ($past(periph_oe_i) & ~crossbar_skip_o))
    else $error("peripheral drives a skipped pin");
  a_pin_pass: assert property ($past(rst_n_i) |-> pin_out_o == $past(periph_out_i))
    else $error("peripheral output disturbed");
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_prio_ro: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'hF7 |-> reg_rdata_o[7:4] == 4'h0)
    else $error("read-only priority bits not zero");
  a_tctl_pend: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h88 |->
    reg_rdata_o[3] == $past(ext_irq_pending_o[1]) && reg_rdata_o[1] == $past(ext_irq_pending_o[0]))
    else $error("pending bits misplaced in timer control");
  a_pend_steady: assert property ((!reg_wr_i && ext_irq_vector_i == 2'h0 && $stable(port0_pin_i[5:0])
    && $stable(port1_pin_i[7:6]))[*5] |-> $stable(ext_irq_pending_o))
    else $error("pending changed without cause");
endmodule : exi_top_chk

bind exi_top exi_top_chk u_exi_top_chk (.*);

// >>> exi_src_model.sv
// Behavioural external interrupt sources on the selectable port pins
`timescale 1ns/1ps
module exi_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Requests and pin wiring
  input wire logic [1:0] act_i,
  input wire logic [7:0] cfg_i,
  // Port pins
  output logic [7:0] port0_pin_o,
  output logic [7:0] port1_pin_o
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [7:0] noise_q = 8'h5A;
  logic [7:0] pins;

  // Port pins the block never gathers keep changing; unowned gathered pins stay high
  always_ff @(posedge clk_sys_i) begin
    noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5]};
  end

  always_comb begin
    pins = 8'hFF;
    pins[cfg_i[2:0]] = act_i[0] ~^ cfg_i[3];
    pins[cfg_i[6:4]] = act_i[1] ~^ cfg_i[7];
    port0_pin_o = {noise_q[7:6], pins[5:0]};
    port1_pin_o = {pins[7:6], noise_q[5:0]};
  end
endmodule : exi_src_model

// >>> test_ext_interrupt_and_priority2.sv
// Self-checking bench of the external interrupt and priority block
`timescale 1ns/1ps
module test_ext_interrupt_and_priority2;
  // ----------------------------------------------------------------
  // Stimulus, instances and checks
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] src_irq_i = 8'h00;
  logic [7:0] periph_out_i = 8'h00;
  logic [7:0] periph_oe_i = 8'h00;
  logic [1:0] ext_irq_vector_i = 2'h0;
  logic [1:0] act = 2'h0;
  logic [7:0] cfg = 8'h01;
  logic [7:0] port0_pin, port1_pin, reg_rdata_o, pin_out_o, pin_oe_o, crossbar_skip_o, src_req_high_o, src_req_low_o;
  logic [1:0] ext_irq_pending_o;
  logic irq_o;
  int n_fail = 0;
  int n_tests = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  exi_top u_exi_top (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .port0_pin_i(port0_pin), .port1_pin_i(port1_pin), .periph_out_i, .periph_oe_i, .pin_out_o, .pin_oe_o,
    .crossbar_skip_o, .src_irq_i, .src_req_high_o, .src_req_low_o, .ext_irq_vector_i, .ext_irq_pending_o, .irq_o);
  exi_src_model u_exi_src_model (.clk_sys_i, .act_i(act), .cfg_i(cfg), .port0_pin_o(port0_pin),
    .port1_pin_o(port1_pin));

  function automatic logic [7:0] tctl_exp(input logic i, input logic ed, input logic p);
    return i ? {4'h0, p, ed, 2'h0} : {6'h0, p, ed};
  endfunction : tctl_exp

  function automatic logic [7:0] pend_exp(input logic i, input logic b);
    return b ? (i ? 8'h02 : 8'h01) : 8'h00;
  endfunction : pend_exp

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task automatic smp;
    @(negedge clk_sys_i);
  endtask : smp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    logic [7:0] d, p, s, c;
    logic [2:0] sel;
    logic i, ed, pl;
    static logic [7:0] adr [7] = '{8'hF7, 8'hE4, 8'h88, 8'hD4, 8'hC0, 8'hC2, 8'h05};
    d = 8'($urandom(32'h8E9B));
    cyc(4);
    rst_n_i <= 1'b1;
    foreach (adr[k]) begin
      rd(adr[k], d);
      chk("reset value", (adr[k] == 8'hE4) ? 8'h01 : 8'h00, d);
    end
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      p = (k == 0) ? 8'hFF : 8'($urandom);
      s = 8'($urandom);
      wr(8'hF7, p);
      wr(8'hD4, s);
      cyc(1);
      src_irq_i <= 8'($urandom);
      periph_oe_i <= 8'($urandom);
      periph_out_i <= 8'($urandom);
      cyc(2);
      smp;
      chk("req_high", src_irq_i & p & 8'h0F, src_req_high_o);
      chk("req_low", src_irq_i & ~(p & 8'h0F), src_req_low_o);
      chk("pin_oe", periph_oe_i & ~s, pin_oe_o);
      chk("pin_out", periph_out_i, pin_out_o);
      chk("skip", s, crossbar_skip_o);
      rd(8'hF7, d);
      chk("priority", p & 8'h0F, d);
    end
    $display("test priority and crossbar done");
    wr(8'hC2, 8'h01);
    for (int m = 0; m < 8; m++) begin
      {i, ed, pl} = 3'(m);
      sel = 3'(m * 3);
      c = i ? {pl, sel, 1'b0, sel ^ 3'h1} : {1'b0, sel ^ 3'h1, pl, sel};
      cfg <= c;
      wr(8'hE4, c);
      cyc(4);
      wr(8'h88, tctl_exp(i, ed, 1'b0));
      wr(8'hC1, 8'h03);
      act[i] <= 1'b1;
      cyc(4);
      smp;
      chk("pending", pend_exp(i, 1'b1), {6'h0, ext_irq_pending_o});
      chk("irq", {7'h0, !i}, {7'h0, irq_o});
      rd(8'h88, d);
      chk("tctl", tctl_exp(i, ed, 1'b1), d);
      cyc(1);
      ext_irq_vector_i[i] <= 1'b1;
      cyc(1);
      ext_irq_vector_i <= 2'h0;
      cyc(1);
      smp;
      chk("after vector", pend_exp(i, !ed), {6'h0, ext_irq_pending_o});
      cyc(1);
      act <= 2'h0;
      cyc(4);
      smp;
      chk("released", 8'h00, {6'h0, ext_irq_pending_o});
      wr(8'hC1, 8'h03);
      cyc(2);
      smp;
      chk("irq cleared", 8'h00, {7'h0, irq_o});
    end
    $display("test pin modes done");
    results();
  end
endmodule : test_ext_interrupt_and_priority2
